//--- core/scr_top.v
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// - Unused first-register bits 7,5,4 read zero.
// - Bit 6 picks divider source timer.
// - Divider enable: 00 off, 10 true, 11 both.
// - Disabled divider output frees its pin.
// - Crystal low-power bit: quick start or low power.
// - Clock mode: fast RC, or crystal stopping RC.
// - Clock selections act only in RC-plus-crystal option.
// - Edge field: off, rising, falling, both.
// - Time-base period two to ten..thirteen.
// - Watchdog off only for code 1010.
// - Always-on option ignores the watchdog code.
// - Watchdog stops only with option off, 1010.
// - Selected port A falling edge wakes device.
// - Pull-high on selected input pins only.
// - Fast RC runs at 4, 8 or 12 MHz.
// - Fast RC system clock frees both oscillator pins.
// - External RC uses pin six only.
`include "scr_consts.vh"

module scr_top (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire        hready_in,
    input  wire [31:0] hwdata_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire        has_div_clk_sel_in,
    input  wire [1:0]  osc_config_in,
    input  wire [1:0]  fast_rc_freq_in,
    input  wire        wdt_always_on_in,
    input  wire        sleep_in,
    input  wire [7:0]  port_a_dir_in,
    input  wire [7:0]  port_a_pin_in,
    output wire        divider_clock_select_out,
    output wire        div_true_en_out,
    output wire        div_inv_en_out,
    output wire        div_true_pin_gpio_out,
    output wire        div_inv_pin_gpio_out,
    output wire        crystal_low_power_out,
    output wire        system_clock_select_out,
    output wire        fast_rc_stop_out,
    output wire        ext_int_rise_en_out,
    output wire        ext_int_fall_en_out,
    output wire [3:0]  timebase_log2_out,
    output wire        watchdog_run_out,
    output wire        wake_out,
    output wire [7:0]  pullhigh_en_out,
    output wire [3:0]  fast_rc_mhz_out,
    output wire        port_a_pin5_gpio_out,
    output wire        port_a_pin6_gpio_out
);

    reg  [7:0]  ctrl_first_r;
    reg  [7:0]  ctrl_second_r;
    reg  [7:0]  wake_sel_r;
    reg  [7:0]  pull_sel_r;
    reg         wr_pend_r;
    reg  [5:0]  wr_idx_r;
    reg  [31:0] hrdata_r;
    reg  [31:0] rd_nxt;
    reg  [7:0]  pin_meta_r;
    reg  [7:0]  pin_sync_r;
    reg  [7:0]  pin_prev_r;
    reg         div_sel_r;
    reg         div_true_r;
    reg         div_inv_r;
    reg         div_true_gpio_r;
    reg         div_inv_gpio_r;
    reg         xtal_lp_r;
    reg         slow_r;
    reg         rc_stop_r;
    reg         rise_r;
    reg         fall_r;
    reg  [3:0]  tb_r;
    reg         wdt_run_r;
    reg         wake_r;
    reg  [7:0]  pull_en_r;
    reg  [3:0]  rc_mhz_r;
    reg         pin5_gpio_r;
    reg         pin6_gpio_r;
    reg  [3:0]  rc_mhz_nxt;
    reg         pin5_nxt;
    reg         pin6_nxt;

    wire        addr_ok;
    wire [5:0]  addr_idx;
    wire [7:0]  first_mask;
    wire [7:0]  first_wr;
    wire [1:0]  div_code;
    wire [1:0]  edge_code;
    wire [3:0]  wdt_code;
    wire [1:0]  tb_code;
    wire        sel_valid;
    wire        slow_nxt;
    wire        wdt_nxt;
    wire [7:0]  status_word;
    wire [7:0]  fall_hit;

    // The address phase is taken on every edge where the slave is selected, the bus is ready and the transfer is active.
    assign addr_ok  = hsel_in & hready_in & htrans_in[`SCR_HTRANS_ACT_BIT];
    assign addr_idx = haddr_in[7:2];

    // Bit 6 is writable only on the variant that implements it.
    assign first_mask = has_div_clk_sel_in ?
                        (`SCR_FIRST_BASE_MASK | `SCR_FIRST_SEL_MASK) :
                        `SCR_FIRST_BASE_MASK;
    assign first_wr   = hwdata_in[7:0] & first_mask;

    assign div_code  = ctrl_first_r[`SCR_DIV_EN_HI_BIT:`SCR_DIV_EN_LO_BIT];
    assign edge_code = ctrl_second_r[`SCR_EDGE_MSB:`SCR_EDGE_LSB];
    assign wdt_code  = ctrl_second_r[`SCR_WDT_CODE_MSB:`SCR_WDT_CODE_LSB];
    assign tb_code   = ctrl_second_r[`SCR_TB_MSB:`SCR_TB_LSB];

    // Clock selections only matter with the RC-plus-crystal option.
    assign sel_valid = (osc_config_in == `SCR_OSC_RC_PLUS_XTAL);
    assign slow_nxt  = sel_valid & ctrl_first_r[`SCR_CLK_MODE_BIT];

    assign wdt_nxt = wdt_always_on_in |
                     (wdt_code != `SCR_WDT_OFF_CODE);

    assign status_word = {5'h00, rc_stop_r, slow_r, wdt_run_r};

    assign fall_hit = pin_prev_r & ~pin_sync_r & wake_sel_r;

    // Read data is set up during the address phase for a zero-wait answer.
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (addr_idx)
            `SCR_OFS_CTRL_FIRST: begin
                rd_nxt = {24'h00_0000, ctrl_first_r};
            end
            `SCR_OFS_CTRL_SECOND: begin
                rd_nxt = {24'h00_0000, ctrl_second_r};
            end
            `SCR_OFS_WAKE_SEL: begin
                rd_nxt = {24'h00_0000, wake_sel_r};
            end
            `SCR_OFS_PULL_SEL: begin
                rd_nxt = {24'h00_0000, pull_sel_r};
            end
            `SCR_OFS_STATUS: begin
                rd_nxt = {24'h00_0000, status_word};
            end
            default: begin
                rd_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Bus slave: address phase capture and data phase write.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_r     <= 1'b0;
            wr_idx_r      <= 6'h00;
            hrdata_r      <= 32'h0000_0000;
            ctrl_first_r  <= `SCR_RST_CTRL_FIRST;
            ctrl_second_r <= `SCR_RST_CTRL_SECOND;
            wake_sel_r    <= `SCR_RST_WAKE_SEL;
            pull_sel_r    <= `SCR_RST_PULL_SEL;
        end else begin
            wr_pend_r <= addr_ok & hwrite_in;
            if (addr_ok) begin
                wr_idx_r <= addr_idx;
            end
            if (addr_ok & ~hwrite_in) begin
                hrdata_r <= rd_nxt;
            end
            if (wr_pend_r) begin
                case (wr_idx_r)
                    `SCR_OFS_CTRL_FIRST: begin
                        ctrl_first_r <= first_wr;
                    end
                    `SCR_OFS_CTRL_SECOND: begin
                        ctrl_second_r <= hwdata_in[7:0];
                    end
                    `SCR_OFS_WAKE_SEL: begin
                        wake_sel_r <= hwdata_in[7:0];
                    end
                    `SCR_OFS_PULL_SEL: begin
                        pull_sel_r <= hwdata_in[7:0];
                    end
                    default: begin
                        wake_sel_r <= wake_sel_r;
                    end
                endcase
            end
        end
    end

    // Port A pins come from outside and pass two flip-flops first.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta_r <= 8'hff;
            pin_sync_r <= 8'hff;
            pin_prev_r <= 8'hff;
        end else begin
            pin_meta_r <= port_a_pin_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // Fast RC frequency from the option; the spare code falls back to 4 MHz.
    always @* begin
        rc_mhz_nxt = `SCR_RC_MHZ_4;
        case (fast_rc_freq_in)
            `SCR_RC_CODE_4: begin
                rc_mhz_nxt = `SCR_RC_MHZ_4;
            end
            `SCR_RC_CODE_8: begin
                rc_mhz_nxt = `SCR_RC_MHZ_8;
            end
            `SCR_RC_CODE_12: begin
                rc_mhz_nxt = `SCR_RC_MHZ_12;
            end
            default: begin
                rc_mhz_nxt = `SCR_RC_MHZ_4;
            end
        endcase
    end

    // Oscillator pin sharing per oscillator option.
    always @* begin
        pin5_nxt = 1'b0;
        pin6_nxt = 1'b0;
        case (osc_config_in)
            `SCR_OSC_FAST_XTAL: begin
                pin5_nxt = 1'b0;
                pin6_nxt = 1'b0;
            end
            `SCR_OSC_EXT_RC: begin
                pin5_nxt = 1'b1;
                pin6_nxt = 1'b0;
            end
            `SCR_OSC_FAST_RC: begin
                pin5_nxt = 1'b1;
                pin6_nxt = 1'b1;
            end
            default: begin
                pin5_nxt = 1'b0;
                pin6_nxt = 1'b0;
            end
        endcase
    end

    // Decoded controls, all registered so outputs come from flip-flops.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_sel_r   <= 1'b0;
            div_true_r  <= 1'b0;
            div_inv_r   <= 1'b0;
            div_true_gpio_r <= 1'b1;
            div_inv_gpio_r  <= 1'b1;
            xtal_lp_r   <= 1'b0;
            slow_r      <= 1'b0;
            rc_stop_r   <= 1'b0;
            rise_r      <= 1'b0;
            fall_r      <= 1'b0;
            tb_r        <= `SCR_TB_BASE_LOG2;
            wdt_run_r   <= 1'b1;
            wake_r      <= 1'b0;
            pull_en_r   <= 8'h00;
            rc_mhz_r    <= `SCR_RC_MHZ_4;
            pin5_gpio_r <= 1'b0;
            pin6_gpio_r <= 1'b0;
        end else begin
            div_sel_r  <= ctrl_first_r[`SCR_DIV_CLK_SEL_BIT];
            div_true_r <= (div_code == `SCR_DIV_TRUE_ONLY) |
                          (div_code == `SCR_DIV_BOTH);
            div_inv_r  <= (div_code == `SCR_DIV_BOTH);
            // A disabled divider output hands its pin back to the port.
            div_true_gpio_r <= ~((div_code == `SCR_DIV_TRUE_ONLY) |
                                 (div_code == `SCR_DIV_BOTH));
            div_inv_gpio_r  <= ~(div_code == `SCR_DIV_BOTH);
            xtal_lp_r  <= sel_valid & ctrl_first_r[`SCR_XTAL_LP_BIT];
            slow_r     <= slow_nxt;
            rc_stop_r  <= slow_nxt;
            rise_r     <= (edge_code == `SCR_EDGE_RISE) |
                          (edge_code == `SCR_EDGE_DUAL);
            fall_r     <= (edge_code == `SCR_EDGE_FALL) |
                          (edge_code == `SCR_EDGE_DUAL);
            tb_r       <= `SCR_TB_BASE_LOG2 + {2'b00, tb_code};
            wdt_run_r  <= wdt_nxt;
            wake_r     <= sleep_in & (|fall_hit);
            pull_en_r  <= pull_sel_r & port_a_dir_in;
            rc_mhz_r   <= rc_mhz_nxt;
            pin5_gpio_r <= pin5_nxt;
            pin6_gpio_r <= pin6_nxt;
        end
    end

    assign hrdata_out               = hrdata_r;
    assign hreadyout_out            = 1'b1;
    assign hresp_out                = 1'b0;
    assign divider_clock_select_out = div_sel_r;
    assign div_true_en_out          = div_true_r;
    assign div_inv_en_out           = div_inv_r;
    assign div_true_pin_gpio_out    = div_true_gpio_r;
    assign div_inv_pin_gpio_out     = div_inv_gpio_r;
    assign crystal_low_power_out    = xtal_lp_r;
    assign system_clock_select_out  = slow_r;
    assign fast_rc_stop_out         = rc_stop_r;
    assign ext_int_rise_en_out      = rise_r;
    assign ext_int_fall_en_out      = fall_r;
    assign timebase_log2_out        = tb_r;
    assign watchdog_run_out         = wdt_run_r;
    assign wake_out                 = wake_r;
    assign pullhigh_en_out          = pull_en_r;
    assign fast_rc_mhz_out          = rc_mhz_r;
    assign port_a_pin5_gpio_out     = pin5_gpio_r;
    assign port_a_pin6_gpio_out     = pin6_gpio_r;

endmodule // scr_top

//--- core/scr_consts.vh
`ifndef SCR_CONSTS_VH
`define SCR_CONSTS_VH

// Word indices of the registers; the byte address is four times the index.
`define SCR_OFS_CTRL_FIRST   6'h00
`define SCR_OFS_CTRL_SECOND  6'h01
`define SCR_OFS_WAKE_SEL     6'h02
`define SCR_OFS_PULL_SEL     6'h03
`define SCR_OFS_STATUS       6'h04

// Field positions in the first control register.
`define SCR_CLK_MODE_BIT     0
`define SCR_XTAL_LP_BIT      1
`define SCR_DIV_EN_LO_BIT    2
`define SCR_DIV_EN_HI_BIT    3
`define SCR_DIV_CLK_SEL_BIT  6

// Field positions in the second control register.
`define SCR_WDT_CODE_LSB     0
`define SCR_WDT_CODE_MSB     3
`define SCR_TB_LSB           4
`define SCR_TB_MSB           5
`define SCR_EDGE_LSB         6
`define SCR_EDGE_MSB         7

// Field positions in the status register.
`define SCR_ST_WDT_RUN_BIT   0
`define SCR_ST_SLOW_BIT      1
`define SCR_ST_RC_STOP_BIT   2

// Reset values.
`define SCR_RST_CTRL_FIRST   8'h00
`define SCR_RST_CTRL_SECOND  8'h8a
`define SCR_RST_WAKE_SEL     8'h00
`define SCR_RST_PULL_SEL     8'h00

// Mask of writable positions of the first control register.
`define SCR_FIRST_BASE_MASK  8'h0f
`define SCR_FIRST_SEL_MASK   8'h40

// Codes.
`define SCR_WDT_OFF_CODE     4'ha
`define SCR_DIV_TRUE_ONLY    2'h2
`define SCR_DIV_BOTH         2'h3
`define SCR_EDGE_RISE        2'h1
`define SCR_EDGE_FALL        2'h2
`define SCR_EDGE_DUAL        2'h3
`define SCR_TB_BASE_LOG2     4'ha

// Oscillator configuration option codes.
`define SCR_OSC_FAST_XTAL    2'h0
`define SCR_OSC_EXT_RC       2'h1
`define SCR_OSC_FAST_RC      2'h2
`define SCR_OSC_RC_PLUS_XTAL 2'h3

// Internal fast RC frequency option codes and frequencies in MHz.
`define SCR_RC_CODE_4        2'h0
`define SCR_RC_CODE_8        2'h1
`define SCR_RC_CODE_12       2'h2
`define SCR_RC_MHZ_4         4'h4
`define SCR_RC_MHZ_8         4'h8
`define SCR_RC_MHZ_12        4'hc

// AHB transfer type bit that marks an active transfer.
`define SCR_HTRANS_ACT_BIT   1

`endif

//--- testbench/scr_top_sva.sv
`timescale 1ns/100ps
module scr_top_sva (
    input wire       ref_clk_in,
    input wire       rst_in,
    input wire [1:0] osc_config_in,
    input wire [1:0] fast_rc_freq_in,
    input wire       wdt_always_on_in,
    input wire       sleep_in,
    input wire [7:0] port_a_dir_in,
    input wire       div_true_en_out,
    input wire       div_inv_en_out,
    input wire       div_true_pin_gpio_out,
    input wire       crystal_low_power_out,
    input wire       system_clock_select_out,
    input wire       fast_rc_stop_out,
    input wire [3:0] timebase_log2_out,
    input wire       watchdog_run_out,
    input wire       wake_out,
    input wire [7:0] pullhigh_en_out,
    input wire [3:0] fast_rc_mhz_out,
    input wire       port_a_pin5_gpio_out,
    input wire       port_a_pin6_gpio_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    property p_pin; div_true_pin_gpio_out == !div_true_en_out; endproperty
    a_pin: assert property (p_pin) else $error("divider pin release wrong");
    property p_div; div_inv_en_out |-> div_true_en_out; endproperty
    a_div: assert property (p_div) else $error("inverted output alone");
    property p_osc; $past(osc_config_in) != 2'h3
        |-> !system_clock_select_out && !crystal_low_power_out; endproperty
    a_osc: assert property (p_osc) else $error("clock selection outside option");
    property p_stop; system_clock_select_out |-> fast_rc_stop_out; endproperty
    a_stop: assert property (p_stop) else $error("fast RC not stopped");
    property p_wdt; $past(wdt_always_on_in) |-> watchdog_run_out; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog stopped while forced");
    property p_mhz; !$past(rst_in) |-> fast_rc_mhz_out == (($past(fast_rc_freq_in) == 2'h1)
        ? 4'h8 : ($past(fast_rc_freq_in) == 2'h2) ? 4'hc : 4'h4); endproperty
    a_mhz: assert property (p_mhz) else $error("fast RC frequency wrong");
    property p_rc; !$past(rst_in) && $past(osc_config_in) == 2'h2
        |-> port_a_pin5_gpio_out && port_a_pin6_gpio_out; endproperty
    a_rc: assert property (p_rc) else $error("pins held with fast RC");
    property p_erc; !$past(rst_in) && $past(osc_config_in) == 2'h1
        |-> port_a_pin5_gpio_out && !port_a_pin6_gpio_out; endproperty
    a_erc: assert property (p_erc) else $error("pins wrong with external RC");
    property p_pull; (pullhigh_en_out & ~$past(port_a_dir_in)) == 8'h00; endproperty
    a_pull: assert property (p_pull) else $error("pull-high on output pin");
    property p_wake; wake_out |-> $past(sleep_in); endproperty
    a_wake: assert property (p_wake) else $error("wake while running");
    property p_tb; timebase_log2_out >= 4'ha && timebase_log2_out <= 4'hd; endproperty
    a_tb: assert property (p_tb) else $error("time-base period out of range");
endmodule // scr_top_sva
bind scr_top scr_top_sva u_sva (.*);

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        ref_clk_in, rst_in, hsel_in, hwrite_in, has_div_clk_sel_in;
    logic        wdt_always_on_in, sleep_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
    logic [1:0]  htrans_in, osc_config_in, fast_rc_freq_in;
    logic [2:0]  hsize_in;
    logic [7:0]  port_a_dir_in, port_a_pin_in, pullhigh_en_out, v, s;
    logic [3:0]  timebase_log2_out, fast_rc_mhz_out;
    logic        divider_clock_select_out, div_true_en_out, div_inv_en_out;
    logic        div_true_pin_gpio_out, div_inv_pin_gpio_out, crystal_low_power_out;
    logic        system_clock_select_out, fast_rc_stop_out, ext_int_rise_en_out;
    logic        ext_int_fall_en_out, watchdog_run_out, wake_out;
    logic        port_a_pin5_gpio_out, port_a_pin6_gpio_out;
    int          n_mismatch = 0, checks = 0, cyc = 0;

    scr_top DUT (.hready_in(hreadyout_out), .*);

    task automatic end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input [31:0] seen, input [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single AHB transfer; the wait loops are cut short by the cycle ceiling.
    task automatic bus(input [31:0] a, input w, input [31:0] d, output [31:0] r);
        @(posedge ref_clk_in);
        htrans_in <= 2'h2;
        haddr_in  <= a;
        hwrite_in <= w;
        do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
        r = hrdata_out;
    endtask

    task automatic wake(input [7:0] m, input [31:0] e);
        logic [31:0] n;
        n = 0;
        @(posedge ref_clk_in) port_a_pin_in <= ~m;
        repeat (8) begin
            @(posedge ref_clk_in);
            #1 n += wake_out;
        end
        @(posedge ref_clk_in) port_a_pin_in <= 8'hff;
        repeat (8) @(posedge ref_clk_in);
        chk(n, e);
    endtask

    function automatic [6:0] exp_div(input [7:0] x, input [1:0] o);
        exp_div = {~x[3], ~(x[3] & x[2]), x[6], x[3], x[3] & x[2], (o == 2'h3) & x[1],
                   (o == 2'h3) & x[0]};
    endfunction

    function automatic [6:0] exp_two(input [7:0] x, input a);
        exp_two = {x[6], x[7], 4'ha + {2'h0, x[5:4]}, a | (x[3:0] != 4'ha)};
    endfunction

    function automatic [5:0] exp_osc(input [1:0] o, input [1:0] f);
        exp_osc = {o == 2'h1 || o == 2'h2, o == 2'h2,
                   (f == 2'h1) ? 4'h8 : (f == 2'h2) ? 4'hc : 4'h4};
    endfunction

    initial begin
        ref_clk_in = 0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            end_of_test;
        end
    end

    initial begin
        rst_in = 1; hsel_in = 1; hsize_in = 3'h2; htrans_in = 0; haddr_in = 0;
        hwrite_in = 0; hwdata_in = 0; has_div_clk_sel_in = 1; osc_config_in = 2'h3;
        fast_rc_freq_in = 0; wdt_always_on_in = 0; sleep_in = 0; port_a_dir_in = 0;
        port_a_pin_in = 8'hff;
        void'($urandom(67143));
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 0;
        for (int i = 0; i < 6; i++) begin
            bus(i * 4, 0, 0, q);
            chk(q, (i == 1) ? 32'h8a : 32'h0);
        end
        chk({hresp_out, watchdog_run_out}, 0);
        for (int i = 0; i < 40; i++) begin
            v = $urandom;
            s = $urandom;
            if (i % 3 == 0) s[3:0] = 4'ha;
            if (i == 0) v = 8'hff;
            osc_config_in <= $urandom;
            fast_rc_freq_in <= $urandom;
            wdt_always_on_in <= $urandom;
            bus(0, 1, v, q);
            bus(4, 1, s, q);
            repeat (2) @(posedge ref_clk_in);
            #1;
            chk({div_true_pin_gpio_out, div_inv_pin_gpio_out, divider_clock_select_out,
                 div_true_en_out, div_inv_en_out, crystal_low_power_out,
                 system_clock_select_out}, exp_div(v, osc_config_in));
            chk({ext_int_rise_en_out, ext_int_fall_en_out, timebase_log2_out,
                 watchdog_run_out}, exp_two(s, wdt_always_on_in));
            chk({port_a_pin5_gpio_out, port_a_pin6_gpio_out, fast_rc_mhz_out},
                exp_osc(osc_config_in, fast_rc_freq_in));
            if (osc_config_in == 2'h3) chk(fast_rc_stop_out, v[0]);
            bus(0, 0, 0, q);
            chk(q, v & 8'h4f);
            bus(4, 0, 0, q);
            chk(q, s);
            bus(16, 0, 0, q);
            chk(q, {29'h0, {2{osc_config_in == 2'h3 && v[0]}},
                    wdt_always_on_in | (s[3:0] != 4'ha)});
        end
        has_div_clk_sel_in <= 0;
        bus(0, 1, 32'hff, q);
        repeat (2) @(posedge ref_clk_in);
        #1 chk(divider_clock_select_out, 0);
        bus(0, 0, 0, q);
        chk(q, 32'h0f);
        v = $urandom;
        s = $urandom;
        port_a_dir_in <= s;
        bus(8, 1, 32'h21, q);
        bus(12, 1, v, q);
        repeat (2) @(posedge ref_clk_in);
        #1 chk(pullhigh_en_out, v & s);
        bus(12, 0, 0, q);
        chk(q, v);
        @(posedge ref_clk_in) sleep_in <= 1;
        wake(8'h01, 1);
        wake(8'h02, 0);
        wake(8'h20, 1);
        @(posedge ref_clk_in) sleep_in <= 0;
        wake(8'h01, 0);
        end_of_test;
    end
endmodule // testbench
